/* bench/chip_config_regs_assertions.sv */
// Port assertions for the configuration and station address bank
module chip_config_regs_assertions #(
    parameter int SK_HALF = cfg_regs_pkg::EE_SK_HALF
) (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic HOST_SEL_I,
    input wire logic HOST_WR_I,
    input wire logic HOST_RD_I,
    input wire logic [7:0] HOST_ADDR_I,
    input wire logic [1:0] HOST_BE_I,
    input wire logic [15:0] HOST_WDATA_I,
    input wire logic [15:0] HOST_RDATA_O,
    input wire logic HOST_RVALID_O,
    input wire logic EEPROM_SERIAL_CLOCK_PIN_O,
    input wire logic EEPROM_SERIAL_CLOCK_PIN_OE_O,
    input wire logic EEPROM_DATA_PIN_OE_O,
    input wire logic EEPROM_CS_O,
    input wire logic PORT_LED_STRAP_PIN_I,
    input wire logic SHARED_BUS_STRAP_I,
    input wire logic PACKAGE_48PIN_I,
    input wire logic [1:0] BUS_CLK_DIV_O,
    input wire logic BUS_CLK_SEL_O,
    input wire logic PAD_DRIVE_16MA_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);
    logic rd;
    logic wr;
    logic bcw;
    logic [15:0] hcnt_q;
    assign rd = HOST_SEL_I && HOST_RD_I && !HOST_WR_I;
    assign wr = HOST_SEL_I && HOST_WR_I;
    assign bcw = wr && HOST_ADDR_I == 8'h20 && HOST_BE_I[0];
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            hcnt_q <= 16'h0000;
        end else begin
            hcnt_q <= EEPROM_SERIAL_CLOCK_PIN_O ? hcnt_q + 16'h0001 : 16'h0000;
        end
    end
    sequence s_wr(a, m);
        wr && !EEPROM_CS_O && HOST_ADDR_I == a && HOST_BE_I == 2'h3 && (HOST_WDATA_I & m) == m;
    endsequence
    sequence s_rd(a);
        rd && HOST_ADDR_I == a;
    endsequence
    property p_rw(a);
        s_wr(a, 16'h0000) ##1 s_rd(a) |=> HOST_RDATA_O == $past(HOST_WDATA_I, 2);
    endproperty
    AST_RVALID_PULSE: assert property (rd |=> HOST_RVALID_O)
        else $error("read without valid");
    AST_RVALID_ONLY: assert property (!rd |=> !HOST_RVALID_O)
        else $error("valid without read");
    AST_CFG_FIELDS: assert property (s_rd(8'h08) |=>
        HOST_RDATA_O[15:11] == 5'h00 && HOST_RDATA_O[8] == 1'b0 && HOST_RDATA_O[5] == 1'b0
        && HOST_RDATA_O[3:2] == 2'h0 && HOST_RDATA_O[0] == 1'b0 && HOST_RDATA_O[6] == $past(PORT_LED_STRAP_PIN_I)
        && HOST_RDATA_O[7] == !$past(PORT_LED_STRAP_PIN_I) && HOST_RDATA_O[4] == $past(SHARED_BUS_STRAP_I)
        && HOST_RDATA_O[1] == $past(PACKAGE_48PIN_I))
        else $error("config fields wrong");
    AST_BC_WRITE: assert property (bcw |=> BUS_CLK_DIV_O == $past(HOST_WDATA_I[1:0])
        && BUS_CLK_SEL_O == $past(HOST_WDATA_I[2]) && PAD_DRIVE_16MA_O == $past(HOST_WDATA_I[6]))
        else $error("bus control outputs wrong");
    AST_BC_HOLD: assert property (!bcw |=> $stable(BUS_CLK_DIV_O) && $stable(BUS_CLK_SEL_O)
        && $stable(PAD_DRIVE_16MA_O))
        else $error("bus control changed unasked");
    AST_SA_LOW_RW: assert property (p_rw(8'h10))
        else $error("low address readback wrong");
    AST_SA_MID_RW: assert property (p_rw(8'h12))
        else $error("middle address readback wrong");
    AST_SA_HIGH_RW: assert property (p_rw(8'h14))
        else $error("high address readback wrong");
    AST_UNMAPPED: assert property (s_rd(8'h30) |=> HOST_RDATA_O == 16'h0000)
        else $error("unmapped read not zero");
    AST_STAT_AC: assert property (s_wr(8'h16, 16'h0000) ##1 s_rd(8'h16) |=> !HOST_RDATA_O[2])
        else $error("auto clear bit kept");
    AST_STAT_W1C: assert property (s_wr(8'h16, 16'h0001) ##1 s_rd(8'h16) |=> !HOST_RDATA_O[0])
        else $error("write one did not clear");
    AST_SK_HIGH: assert property ($fell(EEPROM_SERIAL_CLOCK_PIN_O) |-> hcnt_q == SK_HALF)
        else $error("serial clock high phase wrong");
    AST_CS_DRIVE: assert property (EEPROM_CS_O |-> EEPROM_DATA_PIN_OE_O && EEPROM_SERIAL_CLOCK_PIN_OE_O)
        else $error("pins not driven during load");
endmodule

bind chip_config_regs chip_config_regs_assertions #(.SK_HALF(SK_HALF)) chk_u (
    .CLK_SYS_I, .RSTN_I, .HOST_SEL_I, .HOST_WR_I, .HOST_RD_I, .HOST_ADDR_I, .HOST_BE_I, .HOST_WDATA_I,
    .HOST_RDATA_O, .HOST_RVALID_O, .EEPROM_SERIAL_CLOCK_PIN_O, .EEPROM_SERIAL_CLOCK_PIN_OE_O,
    .EEPROM_DATA_PIN_OE_O, .EEPROM_CS_O, .PORT_LED_STRAP_PIN_I, .SHARED_BUS_STRAP_I, .PACKAGE_48PIN_I,
    .BUS_CLK_DIV_O, .BUS_CLK_SEL_O, .PAD_DRIVE_16MA_O
);

/* bench/eeprom_model.sv */
// Serial EEPROM model answering word read commands
module eeprom_model (
    input wire logic cs_i,
    input wire logic sk_i,
    input wire logic di_i,
    output logic do_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [4];
    logic [8:0] cmd;
    int n;
    initial begin
        mem = '{16'hffff, 16'h89ab, 16'h4567, 16'h0123};
        cmd = 9'h000;
        n = 0;
        do_o = 1'b0;
    end
    always @(posedge cs_i) begin
        n = 0;
    end
    // Command in, dummy zero, then word MSB first
    always @(posedge sk_i) begin
        if (cs_i) begin
            n = n + 1;
            if (n <= 9) begin
                cmd = {cmd[7:0], di_i};
            end else if (n == 10) begin
                do_o = 1'b0;
            end else if (n <= 26) begin
                do_o = (cmd[8:2] == 7'b1100000) ? mem[cmd[1:0]][26 - n] : ~do_o;
            end
        end
    end
    always @(negedge cs_i) begin
        do_o = ~do_o;
    end
endmodule

/* bench/test_chip_config_regs.sv */
// Testbench for the configuration and station address bank
module test_chip_config_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rstn = 1'b0, sel = 1'b0, wen = 1'b0, ren = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [1:0] be = 2'h0;
    logic [15:0] wdata = 16'h0000, rdata, v;
    logic rvalid, sk_o, sk_oe, dt_o, dt_oe, cs, ee_do, sel_o, drv;
    logic [1:0] div;
    logic [4:0] st = 5'h00;
    logic [15:0] sa [3] = '{16'h1122, 16'h3344, 16'h5566};
    int failures = 0, comparisons = 0, cyc = 0;
    chip_config_regs #(.SK_HALF(2)) dut_u (
        .CLK_SYS_I(clk), .RSTN_I(rstn), .HOST_SEL_I(sel), .HOST_WR_I(wen), .HOST_RD_I(ren),
        .HOST_ADDR_I(addr), .HOST_BE_I(be), .HOST_WDATA_I(wdata), .HOST_RDATA_O(rdata), .HOST_RVALID_O(rvalid),
        .EEPROM_SERIAL_CLOCK_PIN_I(sk_oe ? sk_o : st[4]), .EEPROM_SERIAL_CLOCK_PIN_O(sk_o),
        .EEPROM_SERIAL_CLOCK_PIN_OE_O(sk_oe), .EEPROM_DATA_PIN_I(dt_oe ? ee_do : st[3]),
        .EEPROM_DATA_PIN_O(dt_o), .EEPROM_DATA_PIN_OE_O(dt_oe), .EEPROM_CS_O(cs),
        .PORT_LED_STRAP_PIN_I(st[2]), .SHARED_BUS_STRAP_I(st[1]), .PACKAGE_48PIN_I(st[0]),
        .BUS_CLK_DIV_O(div), .BUS_CLK_SEL_O(sel_o), .PAD_DRIVE_16MA_O(drv)
    );
    eeprom_model ee_u (.cs_i(cs), .sk_i(sk_o), .di_i(dt_o), .do_o(ee_do));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic final_report;
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
        sel <= 1'b1;
        wen <= 1'b1;
        ren <= 1'b0;
        addr <= a;
        be <= b;
        wdata <= d;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        sel <= 1'b1;
        wen <= 1'b0;
        ren <= 1'b1;
        addr <= a;
        @(posedge clk);
        sel <= 1'b0;
        ren <= 1'b0;
        @(posedge clk);
        q = rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        rd(a, q);
        chk(q, e);
    endtask
    task automatic do_reset(input logic [4:0] s);
        int k;
        rstn <= 1'b0;
        sel <= 1'b0;
        wen <= 1'b0;
        ren <= 1'b0;
        st <= s;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        v = 16'h0000;
        for (k = 0; k < 300 && s[3] && v[0] !== 1'b1; k++) begin
            rd(8'h16, v);
        end
    endtask
    initial begin
        do_reset(5'h1f);
        rdc(8'h08, 16'h0652);
        rdc(8'h10, 16'h89ab);
        rdc(8'h12, 16'h4567);
        rdc(8'h14, 16'h0123);
        rdc(8'h20, 16'h0000);
        chk({12'h000, drv, sel_o, div}, 16'h0000);
        wr(8'h08, 16'hffff, 2'h3);
        rdc(8'h08, 16'h0652);
        rdc(8'h30, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = {9'h000, i[0], 3'h0, i == 3, i[1:0]};
            wr(8'h20, v, 2'h3);
            rdc(8'h20, v);
            chk({12'h000, drv, sel_o, div}, {12'h000, v[6], v[2], v[1:0]});
        end
        wr(8'h20, 16'hffff, 2'h2);
        rdc(8'h20, 16'hff47);
        chk({12'h000, drv, sel_o, div}, 16'h000f);
        for (int i = 0; i < 3; i++) begin
            wr(8'h10 + 8'(2 * i), sa[i], 2'h3);
            rdc(8'h10 + 8'(2 * i), sa[i]);
        end
        rdc(8'h16, 16'h0005);
        wr(8'h16, 16'h0000, 2'h3);
        rdc(8'h16, 16'h0001);
        wr(8'h16, 16'h0001, 2'h3);
        rdc(8'h16, 16'h0000);
        do_reset(5'h1f);
        rdc(8'h10, 16'h89ab);
        rdc(8'h14, 16'h0123);
        do_reset(5'h00);
        repeat (400) @(posedge clk);
        chk({15'h0000, cs}, 16'h0000);
        rdc(8'h08, 16'h0080);
        rdc(8'h10, 16'h0000);
        wr(8'h12, 16'hbeef, 2'h3);
        rdc(8'h12, 16'hbeef);
        wr(8'h12, 16'h1234, 2'h1);
        rdc(8'h12, 16'hbe34);
        final_report();
    end
endmodule

/* design/cfg_regs_pkg.sv */
// Constants and types for the configuration and station address bank
package cfg_regs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_SA_LOW = 8'h10;
    localparam logic [7:0] OFS_SA_MID = 8'h12;
    localparam logic [7:0] OFS_SA_HIGH = 8'h14;
    localparam logic [7:0] OFS_LOAD_STAT = 8'h16;
    localparam logic [7:0] OFS_BUS_CTRL = 8'h20;
    localparam int CFG_ENDIAN_BIT = 10;
    localparam int CFG_EE_PRESENT_BIT = 9;
    localparam int CFG_BUS8_BIT = 7;
    localparam int CFG_BUS16_BIT = 6;
    localparam int CFG_SHARED_BIT = 4;
    localparam int CFG_PKG48_BIT = 1;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_SWWR_BIT = 2;
    localparam int BC_DRIVE_BIT = 6;
    localparam int BC_CLKSEL_BIT = 2;
    localparam int BC_DIV_LSB = 0;
    localparam logic [15:0] BUS_CTRL_RESET = 16'h0000;
    localparam logic [15:0] SA_RESET = 16'h0000;
    localparam logic [5:0] EE_FIRST_WORD = 6'h01;
    localparam logic [2:0] EE_READ_CMD = 3'b110;
    localparam logic [1:0] EE_WORDS = 2'h3;
    localparam logic [4:0] EE_CMD_LAST = 5'h08;
    localparam logic [4:0] EE_DATA_LAST = 5'h10;
    localparam int SYS_CLK_MHZ = 100;
    localparam int EE_SK_KHZ = 1000;
    localparam int EE_SK_HALF = SYS_CLK_MHZ * 1000 / (2 * EE_SK_KHZ);
    typedef enum logic [2:0] {
        L_IDLE,
        L_LOAD,
        L_CMD,
        L_DATA,
        L_GAP,
        L_DONE
    } load_state_t;
endpackage

/* design/chip_config_regs.sv */
// Chip configuration, station address and internal bus control registers
module chip_config_regs #(
    parameter int SK_HALF = cfg_regs_pkg::EE_SK_HALF
) (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic HOST_SEL_I,
    input wire logic HOST_WR_I,
    input wire logic HOST_RD_I,
    input wire logic [7:0] HOST_ADDR_I,
    input wire logic [1:0] HOST_BE_I,
    input wire logic [15:0] HOST_WDATA_I,
    output logic [15:0] HOST_RDATA_O,
    output logic HOST_RVALID_O,
    input wire logic EEPROM_SERIAL_CLOCK_PIN_I,
    output logic EEPROM_SERIAL_CLOCK_PIN_O,
    output logic EEPROM_SERIAL_CLOCK_PIN_OE_O,
    input wire logic EEPROM_DATA_PIN_I,
    output logic EEPROM_DATA_PIN_O,
    output logic EEPROM_DATA_PIN_OE_O,
    output logic EEPROM_CS_O,
    input wire logic PORT_LED_STRAP_PIN_I,
    input wire logic SHARED_BUS_STRAP_I,
    input wire logic PACKAGE_48PIN_I,
    output logic [1:0] BUS_CLK_DIV_O,
    output logic BUS_CLK_SEL_O,
    output logic PAD_DRIVE_16MA_O
);
    if (SK_HALF < 1 || SK_HALF > 255) begin
        $error("SK_HALF out of range");
    end

    typedef struct packed {
        logic [15:0] sa_low;
        logic [15:0] sa_mid;
        logic [15:0] sa_high;
        logic [15:0] bus_ctrl;
        logic load_done;
        logic sw_wr_seen;
        logic started;
        logic [15:0] rdata;
        logic rvalid;
        logic sk_oe;
        logic loader_done_seen;
    } regs_t;

    localparam regs_t REGS_RESET = '{
        sa_low: cfg_regs_pkg::SA_RESET,
        sa_mid: cfg_regs_pkg::SA_RESET,
        sa_high: cfg_regs_pkg::SA_RESET,
        bus_ctrl: cfg_regs_pkg::BUS_CTRL_RESET,
        load_done: 1'b0,
        sw_wr_seen: 1'b0,
        started: 1'b0,
        rdata: 16'h0000,
        rvalid: 1'b0,
        sk_oe: 1'b0,
        loader_done_seen: 1'b0
    };

    regs_t q;
    regs_t d;

    logic [4:0] straps;
    logic straps_valid;
    logic ld_cs;
    logic ld_sk;
    logic ld_dout;
    logic ld_busy;
    logic ld_done;
    logic ld_wr;
    logic [1:0] ld_idx;
    logic [15:0] ld_word;
    logic [15:0] cfg_word;
    logic [15:0] stat_word;
    logic wr_any;
    logic rd_any;
    logic ld_start;
    logic strap_endian;
    logic strap_ee_present;
    logic strap_bus16;
    logic strap_shared;
    logic strap_pkg48;
    logic hit_sa_low;
    logic hit_sa_mid;
    logic hit_sa_high;
    logic sa_write;

    strap_capture u_strap (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RSTN_I),
        .pins_i({EEPROM_SERIAL_CLOCK_PIN_I, EEPROM_DATA_PIN_I, PORT_LED_STRAP_PIN_I,
                 SHARED_BUS_STRAP_I, PACKAGE_48PIN_I}),
        .straps_o(straps),
        .valid_o(straps_valid)
    );

    eeprom_addr_loader #(
        .SK_HALF(SK_HALF)
    ) u_loader (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RSTN_I),
        .start_i(ld_start),
        .din_i(EEPROM_DATA_PIN_I),
        .cs_o(ld_cs),
        .sk_o(ld_sk),
        .dout_o(ld_dout),
        .busy_o(ld_busy),
        .done_o(ld_done),
        .wr_o(ld_wr),
        .idx_o(ld_idx),
        .word_o(ld_word)
    );

    // Load only when the presence strap says an EEPROM is fitted
    assign {strap_endian, strap_ee_present, strap_bus16, strap_shared, strap_pkg48} = straps;
    assign ld_start = straps_valid && strap_ee_present && !q.started;

    function automatic logic [15:0] merge(
        input logic [15:0] old,
        input logic [15:0] wdata,
        input logic [1:0] be
    );
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

    always_comb begin
        cfg_word = 16'h0000;
        cfg_word[cfg_regs_pkg::CFG_ENDIAN_BIT] = strap_endian;
        cfg_word[cfg_regs_pkg::CFG_EE_PRESENT_BIT] = strap_ee_present;
        cfg_word[cfg_regs_pkg::CFG_BUS8_BIT] = !strap_bus16;
        cfg_word[cfg_regs_pkg::CFG_BUS16_BIT] = strap_bus16;
        cfg_word[cfg_regs_pkg::CFG_SHARED_BIT] = strap_shared;
        cfg_word[cfg_regs_pkg::CFG_PKG48_BIT] = strap_pkg48;
    end

    always_comb begin
        stat_word = 16'h0000;
        stat_word[cfg_regs_pkg::STAT_DONE_BIT] = q.load_done;
        stat_word[cfg_regs_pkg::STAT_BUSY_BIT] = ld_busy;
        stat_word[cfg_regs_pkg::STAT_SWWR_BIT] = q.sw_wr_seen;
    end

    assign wr_any = HOST_SEL_I && HOST_WR_I;
    assign rd_any = HOST_SEL_I && HOST_RD_I && !HOST_WR_I;
    assign sa_write = wr_any && (hit_sa_low || hit_sa_mid || hit_sa_high);

    // Station address offsets
    always_comb begin
        hit_sa_low = (HOST_ADDR_I == cfg_regs_pkg::OFS_SA_LOW);
        hit_sa_mid = (HOST_ADDR_I == cfg_regs_pkg::OFS_SA_MID);
        hit_sa_high = (HOST_ADDR_I == cfg_regs_pkg::OFS_SA_HIGH);
    end

    always_comb begin
        d = q;
        d.rvalid = 1'b0;
        if (ld_start) begin
            d.started = 1'b1;
        end
        d.sk_oe = ld_busy;
        d.loader_done_seen = ld_done;
        // Loaded words land in order low, middle, high
        if (ld_wr) begin
            case (ld_idx)
                2'h0: begin
                    d.sa_low = ld_word;
                end
                2'h1: begin
                    d.sa_mid = ld_word;
                end
                2'h2: begin
                    d.sa_high = ld_word;
                end
                default: begin
                    d.sa_low = q.sa_low;
                end
            endcase
        end
        if (wr_any) begin
            case (HOST_ADDR_I)
                cfg_regs_pkg::OFS_SA_LOW: begin
                    d.sa_low = merge(q.sa_low, HOST_WDATA_I, HOST_BE_I);
                end
                cfg_regs_pkg::OFS_SA_MID: begin
                    d.sa_mid = merge(q.sa_mid, HOST_WDATA_I, HOST_BE_I);
                end
                cfg_regs_pkg::OFS_SA_HIGH: begin
                    d.sa_high = merge(q.sa_high, HOST_WDATA_I, HOST_BE_I);
                end
                cfg_regs_pkg::OFS_BUS_CTRL: begin
                    d.bus_ctrl = merge(q.bus_ctrl, HOST_WDATA_I, HOST_BE_I);
                end
                cfg_regs_pkg::OFS_LOAD_STAT: begin
                    if (HOST_BE_I[0] && HOST_WDATA_I[cfg_regs_pkg::STAT_DONE_BIT]) begin
                        d.load_done = 1'b0;
                    end
                    d.sw_wr_seen = 1'b0;
                end
                default: begin
                    d.bus_ctrl = q.bus_ctrl;
                end
            endcase
        end
        // Hardware sets win over same-cycle clears
        if (ld_done && !q.loader_done_seen) begin
            d.load_done = 1'b1;
        end
        if (sa_write) begin
            d.sw_wr_seen = 1'b1;
        end
        if (rd_any) begin
            d.rvalid = 1'b1;
            case (HOST_ADDR_I)
                cfg_regs_pkg::OFS_CONFIG: begin
                    d.rdata = cfg_word;
                end
                cfg_regs_pkg::OFS_SA_LOW: begin
                    d.rdata = q.sa_low;
                end
                cfg_regs_pkg::OFS_SA_MID: begin
                    d.rdata = q.sa_mid;
                end
                cfg_regs_pkg::OFS_SA_HIGH: begin
                    d.rdata = q.sa_high;
                end
                cfg_regs_pkg::OFS_LOAD_STAT: begin
                    d.rdata = stat_word;
                end
                cfg_regs_pkg::OFS_BUS_CTRL: begin
                    d.rdata = q.bus_ctrl;
                end
                default: begin
                    d.rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            q <= REGS_RESET;
        end else begin
            q <= d;
        end
    end

    assign HOST_RDATA_O = q.rdata;
    assign HOST_RVALID_O = q.rvalid;
    assign EEPROM_SERIAL_CLOCK_PIN_O = ld_sk;
    assign EEPROM_SERIAL_CLOCK_PIN_OE_O = q.sk_oe;
    assign EEPROM_DATA_PIN_O = ld_dout;
    assign EEPROM_DATA_PIN_OE_O = ld_cs;
    assign EEPROM_CS_O = ld_cs;
    assign BUS_CLK_DIV_O = q.bus_ctrl[cfg_regs_pkg::BC_DIV_LSB +: 2];
    assign BUS_CLK_SEL_O = q.bus_ctrl[cfg_regs_pkg::BC_CLKSEL_BIT];
    assign PAD_DRIVE_16MA_O = q.bus_ctrl[cfg_regs_pkg::BC_DRIVE_BIT];
endmodule

/* design/eeprom_addr_loader.sv */
// Serial EEPROM reader that fetches the three station address words
module eeprom_addr_loader #(
    parameter int SK_HALF = cfg_regs_pkg::EE_SK_HALF
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic din_i,
    output logic cs_o,
    output logic sk_o,
    output logic dout_o,
    output logic busy_o,
    output logic done_o,
    output logic wr_o,
    output logic [1:0] idx_o,
    output logic [15:0] word_o
);
    if (SK_HALF < 1 || SK_HALF > 255) begin
        $error("SK_HALF out of range");
    end

    typedef struct packed {
        cfg_regs_pkg::load_state_t st;
        logic [7:0] div;
        logic [4:0] bitn;
        logic [1:0] word;
        logic [15:0] shf;
        logic cs;
        logic sk;
        logic dout;
        logic wr;
    } ld_t;

    localparam logic [7:0] HALF_LAST = 8'(SK_HALF - 1);

    ld_t q;
    ld_t d;
    logic tick;
    logic [5:0] ee_addr;

    always_comb begin
        d = q;
        d.wr = 1'b0;
        tick = (q.div == HALF_LAST);
        ee_addr = cfg_regs_pkg::EE_FIRST_WORD + {4'h0, q.word};
        d.div = tick ? 8'h00 : q.div + 8'h01;
        case (q.st)
            cfg_regs_pkg::L_IDLE: begin
                d.div = 8'h00;
                if (start_i) begin
                    d.st = cfg_regs_pkg::L_LOAD;
                end
            end
            cfg_regs_pkg::L_LOAD: begin
                d.cs = 1'b1;
                d.sk = 1'b0;
                d.bitn = 5'h00;
                d.div = 8'h00;
                d.shf = {cfg_regs_pkg::EE_READ_CMD, ee_addr, 7'h00};
                d.dout = cfg_regs_pkg::EE_READ_CMD[2];
                d.st = cfg_regs_pkg::L_CMD;
            end
            cfg_regs_pkg::L_CMD: begin
                if (tick) begin
                    d.sk = ~q.sk;
                    if (q.sk) begin
                        d.shf = {q.shf[14:0], 1'b0};
                        d.dout = q.shf[14];
                        d.bitn = q.bitn + 5'h01;
                        if (q.bitn == cfg_regs_pkg::EE_CMD_LAST) begin
                            d.st = cfg_regs_pkg::L_DATA;
                            d.bitn = 5'h00;
                            d.dout = 1'b0;
                        end
                    end
                end
            end
            cfg_regs_pkg::L_DATA: begin
                if (tick) begin
                    d.sk = ~q.sk;
                    if (q.sk) begin
                        d.shf = {q.shf[14:0], din_i};
                        d.bitn = q.bitn + 5'h01;
                        if (q.bitn == cfg_regs_pkg::EE_DATA_LAST) begin
                            d.wr = 1'b1;
                            d.cs = 1'b0;
                            d.st = cfg_regs_pkg::L_GAP;
                        end
                    end
                end
            end
            cfg_regs_pkg::L_GAP: begin
                if (tick) begin
                    if (q.word == cfg_regs_pkg::EE_WORDS - 2'h1) begin
                        d.st = cfg_regs_pkg::L_DONE;
                    end else begin
                        d.word = q.word + 2'h1;
                        d.st = cfg_regs_pkg::L_LOAD;
                    end
                end
            end
            cfg_regs_pkg::L_DONE: begin
                d.div = 8'h00;
            end
            default: begin
                d.st = cfg_regs_pkg::L_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cs_o = q.cs;
    assign sk_o = q.sk;
    assign dout_o = q.dout;
    assign busy_o = (q.st != cfg_regs_pkg::L_IDLE) && (q.st != cfg_regs_pkg::L_DONE);
    assign done_o = (q.st == cfg_regs_pkg::L_DONE);
    assign wr_o = q.wr;
    assign idx_o = q.word;
    assign word_o = q.shf;
endmodule

/* design/strap_capture.sv */
// Captures the strap pin levels once after reset release
module strap_capture (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] pins_i,
    output logic [4:0] straps_o,
    output logic valid_o
);
    typedef struct packed {
        logic valid;
        logic [4:0] straps;
    } strap_t;

    strap_t q;
    strap_t d;

    always_comb begin
        d = q;
        if (!q.valid) begin
            d.valid = 1'b1;
            d.straps = pins_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign straps_o = q.straps;
    assign valid_o = q.valid;
endmodule
